/* File: rtl/pmeg_consts.vh */
// constants for the pulse modulator mode edge generator
//
// Contract
// - period counter runs zero to period_limit, restarts; edges fire on counter match.
// - multiple-output mode drives two phases, equal width, offset, own cycle adjusts.
// - multiple-output mode ignores event two and event four.
// - multiple-output output B may cross period boundary; output A never crosses.
// - multiple-output B rises at fixed position; cycle adjust B changes B width.
// - resonant dead times: e3-e2 and e1+period-e4; their mean is used.
// - resonant A rises at e1, falls at e1+duty-average dead time.
// - resonant B rises at A fall+(e3-e2), falls at filter period-(period-e4).
// - resonant adaptive trigger A at e1+duty+offset, B at e1+duty/2+offset.
// - phase trigger selectable between phase trigger register and filter duty.
// - sample triggers and blanking windows come straight from their registers.
// - triangular mode keeps A inactive, no adaptive trigger; only B driven.
// - triangular B rises at period/2-duty/2+cycle adjust A.
// - triangular B falls at period/2+duty/2+cycle adjust B.
// - leading-edge A falls at e1, rises at e1-duty+cycle adjust A.
// - leading-edge B rises at e4, falls at A rise-(e2-e3).
// - leading-edge adaptive trigger A at e1-duty+offset, B at e1-duty/2+offset.
`ifndef PMEG_CONSTS_VH
`define PMEG_CONSTS_VH

`define PMEG_MODE_MULTI     2'h0
`define PMEG_MODE_RESONANT  2'h1
`define PMEG_MODE_TRIANGLE  2'h2
`define PMEG_MODE_LEADING   2'h3

`define PMEG_ASEL_FULL      1'h0
`define PMEG_ASEL_HALF      1'h1

`define PMEG_PSEL_REG       1'h0
`define PMEG_PSEL_DUTY      1'h1

`define PMEG_OUT_RESET      1'h0
`define PMEG_HALF_SHIFT     1

`endif

/* File: rtl/pmeg_edge_gen.v */
// mode dependent edge placement for one pulse modulator
`timescale 1ns/1ns
`include "pmeg_consts.vh"

module pmeg_edge_gen #(
	parameter W = 16
) (
	// clock and reset
	input  wire         clk,
	input  wire         nrst,
	// mode and selects
	input  wire [1:0]   mode,
	input  wire         adapt_sel,
	input  wire         phase_sel,
	// period and event registers
	input  wire [W-1:0] period_limit,
	input  wire [W-1:0] event1,
	input  wire [W-1:0] event2,
	input  wire [W-1:0] event3,
	input  wire [W-1:0] event4,
	// adjusts and offsets
	input  wire [W-1:0] cycle_adj_a,
	input  wire [W-1:0] cycle_adj_b,
	input  wire [W-1:0] adapt_offset,
	input  wire [W-1:0] phase_trig_reg,
	// fixed trigger and blanking registers
	input  wire [W-1:0] sample_pos1,
	input  wire [W-1:0] sample_pos2,
	input  wire [W-1:0] blank_a_begin,
	input  wire [W-1:0] blank_a_end,
	input  wire [W-1:0] blank_b_begin,
	input  wire [W-1:0] blank_b_end,
	// filter outputs
	input  wire [W-1:0] filter_duty,
	input  wire [W-1:0] filter_period,
	// pulse outputs
	output reg          pulse_output_a,
	output reg          pulse_output_b,
	// triggers and windows
	output reg          adapt_trig,
	output reg          sample_trig1,
	output reg          sample_trig2,
	output reg          blank_a,
	output reg          blank_b,
	output reg          phase_trig,
	output reg          period_start,
	output reg  [W-1:0] period_count
);

	// signed working width keeps negative intermediates visible
	localparam SW = W + 2;

	// fold a signed target into 0..period_limit
	function [W-1:0] wrap_pos;
		input signed [SW-1:0] x;
		input        [W-1:0]  lim;
		reg   signed [SW-1:0] len;
		begin
			len = $signed({2'h0, lim}) + $signed({{(SW-1){1'b0}}, 1'b1});
			if (x < 0) begin
				wrap_pos = x[W-1:0] + len[W-1:0];
			end else if (x >= len) begin
				wrap_pos = x[W-1:0] - len[W-1:0];
			end else begin
				wrap_pos = x[W-1:0];
			end
		end
	endfunction

	// zero extend an unsigned register into the working width
	function signed [SW-1:0] sx;
		input [W-1:0] v;
		begin
			sx = $signed({2'h0, v});
		end
	endfunction

	// adaptive trigger share: full duty for trigger a, half duty for trigger b
	function signed [SW-1:0] share;
		input                 sel;
		input signed [SW-1:0] full;
		input signed [SW-1:0] half;
		begin
			if (sel == `PMEG_ASEL_HALF) begin
				share = half;
			end else begin
				share = full;
			end
		end
	endfunction

	// set/clear level; clear wins so equal targets give zero width
	function level_next;
		input cur;
		input hit_set;
		input hit_clr;
		begin
			if (hit_clr) begin
				level_next = 1'b0;
			end else if (hit_set) begin
				level_next = 1'b1;
			end else begin
				level_next = cur;
			end
		end
	endfunction

	// counter
	reg  [W-1:0] cnt;
	wire         wrap_now = (cnt >= period_limit);
	wire [W-1:0] next_cnt = wrap_now ? {W{1'b0}} : cnt + {{(W-1){1'b0}}, 1'b1};

	// working terms
	wire signed [SW-1:0] s_e1   = sx(event1);
	wire signed [SW-1:0] s_e2   = sx(event2);
	wire signed [SW-1:0] s_e3   = sx(event3);
	wire signed [SW-1:0] s_e4   = sx(event4);
	wire signed [SW-1:0] s_prd  = sx(period_limit);
	wire signed [SW-1:0] s_duty = sx(filter_duty);
	wire signed [SW-1:0] s_half = sx(filter_duty >> `PMEG_HALF_SHIFT);
	wire signed [SW-1:0] s_fper = sx(filter_period);
	wire signed [SW-1:0] s_ca   = sx(cycle_adj_a);
	wire signed [SW-1:0] s_cb   = sx(cycle_adj_b);
	wire signed [SW-1:0] s_off  = sx(adapt_offset);
	wire signed [SW-1:0] s_mid  = sx(period_limit >> `PMEG_HALF_SHIFT);

	// resonant dead times
	wire signed [SW-1:0] dead1   = s_e3 - s_e2;
	wire signed [SW-1:0] dead2   = s_e1 + s_prd - s_e4;
	// floor of the mean; sum stays well inside the two guard bits
	wire signed [SW-1:0] dead_av = (dead1 + dead2) >>> `PMEG_HALF_SHIFT;

	// combinational targets for the coming period
	reg signed [SW-1:0] t_a_rise;
	reg signed [SW-1:0] t_a_fall;
	reg signed [SW-1:0] t_b_rise;
	reg signed [SW-1:0] t_b_fall;
	reg signed [SW-1:0] t_adp;
	reg                 en_a;
	reg                 en_adp;

	always @* begin
		t_a_rise = s_e1;
		t_a_fall = s_e1;
		t_b_rise = s_e3;
		t_b_fall = s_e3;
		t_adp    = s_off;
		en_a     = 1'b1;
		en_adp   = 1'b1;
		case (mode)
		`PMEG_MODE_MULTI: begin
			// second phase reuses the duty from its own fixed start
			t_a_rise = s_e1;
			t_a_fall = s_e1 + s_duty + s_ca;
			if (t_a_fall > s_prd) begin
				t_a_fall = s_prd;
			end
			t_b_rise = s_e3;
			t_b_fall = s_e3 + s_duty + s_cb;
			t_adp    = s_e1 + share(adapt_sel, s_duty, s_half) + s_off;
		end
		`PMEG_MODE_RESONANT: begin
			t_a_rise = s_e1;
			t_a_fall = s_e1 + s_duty - dead_av;
			t_b_rise = t_a_fall + dead1;
			t_b_fall = s_fper - (s_prd - s_e4);
			t_adp    = s_e1 + share(adapt_sel, s_duty, s_half) + s_off;
		end
		`PMEG_MODE_TRIANGLE: begin
			en_a     = 1'b0;
			en_adp   = 1'b0;
			t_b_rise = s_mid - s_half + s_ca;
			t_b_fall = s_mid + s_half + s_cb;
		end
		`PMEG_MODE_LEADING: begin
			t_a_fall = s_e1;
			t_a_rise = s_e1 - s_duty + s_ca;
			t_b_rise = s_e4;
			t_b_fall = t_a_rise - (s_e2 - s_e3);
			t_adp    = s_e1 - share(adapt_sel, s_duty, s_half) + s_off;
		end
		default: begin
			en_a   = 1'b0;
			en_adp = 1'b0;
		end
		endcase
	end

	// targets held for a whole period so a moving filter cannot skip an edge
	reg [W-1:0] a_rise;
	reg [W-1:0] a_fall;
	reg [W-1:0] b_rise;
	reg [W-1:0] b_fall;
	reg [W-1:0] adp_pos;
	reg [W-1:0] ph_pos;
	reg         a_on;
	reg         adp_on;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt     <= {W{1'b0}};
			a_rise  <= {W{1'b0}};
			a_fall  <= {W{1'b0}};
			b_rise  <= {W{1'b0}};
			b_fall  <= {W{1'b0}};
			adp_pos <= {W{1'b0}};
			ph_pos  <= {W{1'b0}};
			a_on    <= 1'b0;
			adp_on  <= 1'b0;
		end else begin
			cnt <= next_cnt;
			if (wrap_now) begin
				// new equation set takes effect at each period start
				a_rise  <= wrap_pos(t_a_rise, period_limit);
				a_fall  <= wrap_pos(t_a_fall, period_limit);
				b_rise  <= wrap_pos(t_b_rise, period_limit);
				b_fall  <= wrap_pos(t_b_fall, period_limit);
				adp_pos <= wrap_pos(t_adp, period_limit);
				ph_pos  <= (phase_sel == `PMEG_PSEL_DUTY) ? filter_duty : phase_trig_reg;
				a_on    <= en_a;
				adp_on  <= en_adp;
			end
		end
	end

	// edge matches on the running count
	wire hit_ar = (cnt == a_rise);
	wire hit_af = (cnt == a_fall);
	wire hit_br = (cnt == b_rise);
	wire hit_bf = (cnt == b_fall);

	// output a is forced low while its mode leaves it unused
	wire next_a = a_on ? level_next(pulse_output_a, hit_ar, hit_af) :
	              `PMEG_OUT_RESET;
	wire next_b = level_next(pulse_output_b, hit_br, hit_bf);
	wire next_blank_a = level_next(blank_a, (cnt == blank_a_begin),
	                               (cnt == blank_a_end));
	wire next_blank_b = level_next(blank_b, (cnt == blank_b_begin),
	                               (cnt == blank_b_end));

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulse_output_a <= `PMEG_OUT_RESET;
			pulse_output_b <= `PMEG_OUT_RESET;
			adapt_trig     <= 1'b0;
			sample_trig1   <= 1'b0;
			sample_trig2   <= 1'b0;
			blank_a        <= 1'b0;
			blank_b        <= 1'b0;
			phase_trig     <= 1'b0;
			period_start   <= 1'b0;
			period_count   <= {W{1'b0}};
		end else begin
			pulse_output_a <= next_a;
			pulse_output_b <= next_b;
			adapt_trig     <= adp_on && (cnt == adp_pos);
			sample_trig1   <= (cnt == sample_pos1);
			sample_trig2   <= (cnt == sample_pos2);
			blank_a        <= next_blank_a;
			blank_b        <= next_blank_b;
			phase_trig     <= (cnt == ph_pos);
			period_start   <= (cnt == {W{1'b0}});
			period_count   <= cnt;
		end
	end

endmodule // pmeg_edge_gen

/* File: dv/pmeg_edge_gen_sva.sv */
// assertions for the mode edge generator
`timescale 1ns/1ns
`include "pmeg_consts.vh"
module pmeg_edge_gen_sva #(
	parameter W = 16
) (
	// inputs
	input wire         clk,
	input wire         nrst,
	input wire [1:0]   mode,
	input wire [W-1:0] period_limit,
	input wire [W-1:0] sample_pos1,
	input wire [W-1:0] sample_pos2,
	input wire [W-1:0] blank_a_begin,
	input wire [W-1:0] blank_b_end,
	// outputs
	input wire         pulse_output_a,
	input wire         adapt_trig,
	input wire         sample_trig1,
	input wire         sample_trig2,
	input wire         blank_a,
	input wire         blank_b,
	input wire         period_start,
	input wire [W-1:0] period_count
);
	// mode of the running period; inputs must hold steady across the wrap
	reg [1:0] cur_mode;
	always @(posedge clk or negedge nrst)
		if (!nrst)
			cur_mode <= 2'h0;
		else if (period_count == period_limit)
			cur_mode <= mode;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	cnt_wrap_a: assert property (period_count == period_limit |=> period_count == 0)
		else $error("counter did not restart");
	cnt_step_a: assert property (period_count != 0 && $past(nrst)
		|-> period_count == $past(period_count) + 1'b1)
		else $error("counter skipped a value");
	start_pos_a: assert property (period_start |-> period_count == 0)
		else $error("period start off zero");
	trig1_pos_a: assert property (sample_trig1 |-> period_count == sample_pos1 ##1 !sample_trig1)
		else $error("sample trigger one misplaced");
	trig2_pos_a: assert property (period_count == sample_pos2 && $past(nrst) |-> sample_trig2)
		else $error("sample trigger two missing");
	blank_a_on_a: assert property ($rose(blank_a) |-> period_count == blank_a_begin)
		else $error("blanking a begins wrongly");
	blank_b_off_a: assert property ($fell(blank_b) |-> period_count == blank_b_end)
		else $error("blanking b ends wrongly");
	tri_quiet_a: assert property (cur_mode == `PMEG_MODE_TRIANGLE && period_count != 0
		|-> !pulse_output_a && !adapt_trig)
		else $error("output a or adaptive trigger active in triangle");
endmodule // pmeg_edge_gen_sva

bind pmeg_edge_gen pmeg_edge_gen_sva #(.W(W)) chk_u (.*);

/* File: dv/pmeg_filter_model.sv */
// filter stand-in: duty and period outputs on the system clock
`timescale 1ns/1ns
module pmeg_filter_model #(
	parameter W = 16
) (
	// clock and reset
	input  wire         clk,
	input  wire         nrst,
	// demanded on-time
	input  wire [W-1:0] duty_set,
	// filter outputs
	output reg  [W-1:0] filter_duty,
	output reg  [W-1:0] filter_period
);
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			filter_duty   <= {W{1'b0}};
			filter_period <= {W{1'b0}};
		end else begin
			filter_duty   <= duty_set;
			filter_period <= {duty_set[W-2:0], 1'b0};
		end
	end
endmodule // pmeg_filter_model

/* File: dv/pmeg_edge_gen_tb_top.sv */
// self-checking bench for the mode edge generator
`timescale 1ns/1ns
`include "pmeg_consts.vh"
module pmeg_edge_gen_tb_top;
	reg         clk = 1'b0, nrst = 1'b0, asel = 1'b0, psel = 1'b0, pa = 1'b0, pb = 1'b0;
	reg  [1:0]  mode = `PMEG_MODE_MULTI;
	reg  [15:0] e1 = 16'h000a, e2 = 16'h0007, e3 = 16'h0032, e4 = 16'h0009, dset = 16'h0014;
	reg  [15:0] adj_a = 16'h0003, adj_b = 16'h0005, off = 16'h0002, ptr = 16'h0030;
	reg  [15:0] sp1 = 16'h0011, sp2 = 16'h0021, bab = 16'h0008, bae = 16'h000c;
	reg  [15:0] bbb = 16'h0040, bbe = 16'h0044, lim = 16'h0063;
	reg  [15:0] ra, fa, rb, fb, tpos, ppos;
	wire [15:0] duty, fper, pc;
	wire        a, b, at, ph, ps;
	integer     miscompares = 0, checks_done = 0;
	always #5 clk = ~clk;
	pmeg_filter_model #(.W(16)) flt_u (.clk(clk), .nrst(nrst), .duty_set(dset),
		.filter_duty(duty), .filter_period(fper));
	pmeg_edge_gen #(.W(16)) dut_u (.clk(clk), .nrst(nrst), .mode(mode), .adapt_sel(asel),
		.phase_sel(psel), .period_limit(lim), .event1(e1), .event2(e2), .event3(e3),
		.event4(e4), .cycle_adj_a(adj_a), .cycle_adj_b(adj_b), .adapt_offset(off),
		.phase_trig_reg(ptr), .sample_pos1(sp1), .sample_pos2(sp2), .blank_a_begin(bab),
		.blank_a_end(bae), .blank_b_begin(bbb), .blank_b_end(bbe), .filter_duty(duty),
		.filter_period(fper), .pulse_output_a(a), .pulse_output_b(b), .adapt_trig(at),
		.sample_trig1(), .sample_trig2(), .blank_a(), .blank_b(), .phase_trig(ph),
		.period_start(ps), .period_count(pc));
	// period_count shows the matched target in the first cycle of each change
	always @(negedge clk) begin
		if (a && !pa) ra = pc;
		if (!a && pa) fa = pc;
		if (b && !pb) rb = pc;
		if (!b && pb) fb = pc;
		if (at) tpos = pc;
		if (ph) ppos = pc;
		pa = a;
		pb = b;
	end
	task chk(input [15:0] got, input [15:0] exp, input [63:0] nm);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("Error %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	// settings change one cycle after period start, away from the wrap where they are latched
	task sync;
		begin
			@(posedge ps);
			@(negedge clk);
		end
	endtask
	task run;
		begin
			repeat (200) @(negedge clk);
			#2 {ra, fa, rb, fb, tpos, ppos} = {6{16'hffff}};
			repeat (100) @(negedge clk);
			#2;
		end
	endtask
	task t_multi;
		begin
			sync; run;
			chk(ra, 16'h000a, "ra"); chk(fa, 16'h0021, "fa");
			chk(rb, 16'h0032, "rb"); chk(fb, 16'h004b, "fb");
			sync; e2 = 16'h003c; e4 = 16'h0050; run;
			chk(fa, 16'h0021, "fa"); chk(fb, 16'h004b, "fb");
		end
	endtask
	task t_cross;
		begin
			sync; dset = 16'h0046; run;
			chk(fb, 16'h0019, "fb"); chk(fa, 16'h0053, "fa");
			sync; e1 = 16'h003c; dset = 16'h003c; run;
			chk(ra, 16'h003c, "ra"); chk(fa, 16'h0063, "fa");
		end
	endtask
	task t_res;
		begin
			sync; mode = `PMEG_MODE_RESONANT; e1 = 16'h000a; e2 = 16'h0028; e3 = 16'h002c;
			e4 = 16'h0060; dset = 16'h0028; run;
			chk(ra, 16'h000a, "ra"); chk(fa, 16'h002a, "fa");
			chk(rb, 16'h002e, "rb"); chk(fb, 16'h004d, "fb");
			chk(tpos, 16'h0034, "tpos"); chk(ppos, 16'h0030, "ppos");
			sync; asel = `PMEG_ASEL_HALF; psel = `PMEG_PSEL_DUTY; run;
			chk(tpos, 16'h0020, "tpos"); chk(ppos, 16'h0028, "ppos");
		end
	endtask
	task t_tri;
		begin
			sync; mode = `PMEG_MODE_TRIANGLE; dset = 16'h001e; adj_a = 16'h0002;
			adj_b = 16'h0004; run;
			chk(ra & fa & tpos, 16'hffff, "a_quiet");
			chk(rb, 16'h0024, "rb");
			chk(fb - rb, 16'h0020, "width");
			chk(ppos, 16'h001e, "ppos");
		end
	endtask
	task t_lead;
		begin
			sync; mode = `PMEG_MODE_LEADING; e1 = 16'h0050; e2 = 16'h0008; e3 = 16'h0005;
			e4 = 16'h005a; run;
			chk(fa, 16'h0050, "fa"); chk(ra, 16'h0034, "ra");
			chk(rb, 16'h005a, "rb"); chk(fb, 16'h0031, "fb");
			chk(tpos, 16'h0043, "tpos");
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", checks_done, miscompares);
			if (miscompares == 0 && checks_done > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		miscompares = miscompares + 1;
		end_of_test;
	end
	initial begin
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		t_multi;
		t_cross;
		t_res;
		t_tri;
		t_lead;
		end_of_test;
	end
endmodule // pmeg_edge_gen_tb_top
